// >>> common/conv_sel_pkg.sv
package conv_sel_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_SELECTION = 8'h00;
  localparam logic [7:0] ADDR_CONTROL = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_SLEEP = 8'h0C;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CHAN_W = 5;
  localparam int REF_W = 2;
  localparam int SEL_REF_LSB = 6;
  localparam int CTL_START = 0;
  localparam int CTL_AUTO = 1;
  localparam int CTL_ENABLE = 2;
  localparam int CTL_FREE = 3;
  localparam int CTL_IRQ_EN = 4;
  localparam int CTL_PRESC_LSB = 8;
  localparam int PRESC_W = 3;
  localparam int STS_FLAG = 0;
  localparam int STS_BUSY = 1;
  localparam int STS_FIRST = 2;
  localparam int STS_APPLIED_LSB = 8;
  localparam int SLP_MODE_LSB = 0;
  localparam int SLP_MODE_W = 3;

  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam logic [7:0] SEL_RESET = 8'h00;
  localparam logic [PRESC_W-1:0] PRESC_RESET = 3'h0;
  localparam int NORMAL_CYCLES = 13;
  localparam int FIRST_CYCLES = 25;
  localparam int CNT_W = 5;

  // ----------------------------------------------------------------
  // Sleep mode codes
  // ----------------------------------------------------------------
  localparam logic [2:0] SLEEP_IDLE = 3'h0;
  localparam logic [2:0] SLEEP_NOISE = 3'h1;

  typedef struct packed {
    logic [REF_W-1:0] reference_select;
    logic [CHAN_W-1:0] channel_select;
  } selection_t;

  typedef struct packed {
    logic htrans1;
    logic hwrite;
    logic hsel;
    logic [7:0] haddr;
  } ahb_req_t;

  typedef enum logic [1:0] {
    CONV_IDLE,
    CONV_RUN,
    CONV_LAST
  } conv_state_t;

endpackage

// >>> verilog/conv_prescaler.sv
`timescale 1ns/1ps
module conv_prescaler
  import conv_sel_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Control
  input wire logic run,
  input wire logic restart,
  input wire logic [conv_sel_pkg::PRESC_W-1:0] div_sel,
  // Converter clock rising edge
  output logic tick
);

  logic [7:0] count;
  logic [7:0] limit;

  // Divide by 2, 4, ... 256
  always_comb begin
    limit = 8'(({1'b0, 8'h01} << ({1'b0, div_sel} + 4'h1)) - 9'h001);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count <= 8'h00;
    end else if (!run || restart) begin
      count <= 8'h00;
    end else if (count >= limit) begin
      count <= 8'h00;
    end else begin
      count <= count + 8'h01;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick <= 1'b0;
    end else begin
      tick <= run && !restart && (count >= limit);
    end
  end

endmodule // conv_prescaler

// >>> verilog/edge_sync.sv
`timescale 1ns/1ps
module edge_sync (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Asynchronous level in
  input wire logic level_in,
  // Synchronised level and rising pulse
  output logic level_out,
  output logic rise
);

  logic meta;
  logic last;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta <= 1'b0;
      level_out <= 1'b0;
      last <= 1'b0;
    end else begin
      meta <= level_in;
      level_out <= meta;
      last <= level_out;
    end
  end

  assign rise = level_out && !last;

endmodule // edge_sync

// >>> verilog/conv_select_ctrl.sv
`timescale 1ns/1ps
module conv_select_ctrl
  import conv_sel_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Converter core
  input wire logic trigger_in,
  output conv_sel_pkg::selection_t applied_sel,
  output logic sample_start,
  output logic conv_done,
  // CPU sleep handshake
  input wire logic cpu_halted,
  input wire logic sleep_cmd,
  output logic conv_irq,
  output logic cpu_wake
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  selection_t sel_buffer;
  ahb_req_t req;
  logic [7:0] ctl_aux;
  logic start_bit, auto_trigger_enable, converter_enable;
  logic free_run, irq_enable;
  logic [PRESC_W-1:0] presc_sel;
  logic [SLP_MODE_W-1:0] sleep_mode;
  logic conversion_complete_flag;
  logic first_pending;
  conv_state_t state;
  logic [CNT_W-1:0] cycle_cnt;
  logic tick, trig_rise, halted_sync, halted_rise;
  logic wr_sel, wr_ctl, wr_sts, wr_slp, sleep_armed, sleep_conv;
  logic trig_start, trig_pending, sleep_start, begin_conv, finish, busy;
  logic [CNT_W-1:0] length;

  assign busy = (state != CONV_IDLE);
  assign {start_bit, auto_trigger_enable, converter_enable} =
    {ctl_aux[CTL_START], ctl_aux[CTL_AUTO], ctl_aux[CTL_ENABLE]};
  assign free_run = ctl_aux[CTL_FREE];
  assign irq_enable = ctl_aux[CTL_IRQ_EN];

  // ----------------------------------------------------------------
  // Input synchronisers and prescaler
  // ----------------------------------------------------------------
  edge_sync u_trig (
    .hclk(hclk),
    .hresetn(hresetn),
    .level_in(trigger_in),
    .level_out(),
    .rise(trig_rise)
  );

  edge_sync u_halt (
    .hclk(hclk),
    .hresetn(hresetn),
    .level_in(cpu_halted),
    .level_out(halted_sync),
    .rise(halted_rise)
  );

  assign trig_start = auto_trigger_enable && converter_enable &&
                      trig_rise && !busy && !free_run;

  conv_prescaler u_presc (
    .hclk(hclk),
    .hresetn(hresetn),
    .run(converter_enable),
    .restart(trig_start),
    .div_sel(presc_sel),
    .tick(tick)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trig_pending <= 1'b0;
    end else if (!auto_trigger_enable || !converter_enable || begin_conv) begin
      trig_pending <= 1'b0;
    end else if (trig_start) begin
      trig_pending <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // AHB-Lite address phase capture
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req <= '0;
    end else if (hready) begin
      req.hsel <= hsel;
      req.htrans1 <= htrans[1];
      req.hwrite <= hwrite;
      req.haddr <= haddr[7:0];
    end
  end

  assign wr_sel = req.hsel && req.htrans1 && req.hwrite &&
                  (req.haddr == ADDR_SELECTION);
  assign wr_ctl = req.hsel && req.htrans1 && req.hwrite &&
                  (req.haddr == ADDR_CONTROL);
  assign wr_sts = req.hsel && req.htrans1 && req.hwrite &&
                  (req.haddr == ADDR_STATUS);
  assign wr_slp = req.hsel && req.htrans1 && req.hwrite &&
                  (req.haddr == ADDR_SLEEP);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // Read data, one cycle after address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      case (haddr[7:0])
        ADDR_SELECTION: hrdata <= {24'h00_0000, sel_buffer[6:5], 1'b0,
                                   sel_buffer[4:0]};
        ADDR_CONTROL: hrdata <= {21'h00_0000, presc_sel, ctl_aux[7:1],
                                 start_bit || busy};
        ADDR_STATUS: hrdata <= {16'h0000, 1'b0, applied_sel, 5'h00,
                                first_pending, busy,
                                conversion_complete_flag};
        ADDR_SLEEP: hrdata <= {29'h0000_0000, sleep_mode};
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sel_buffer <= selection_t'(7'h00);
    end else if (wr_sel) begin
      sel_buffer <= selection_t'({hwdata[SEL_REF_LSB +: REF_W],
                                  hwdata[CHAN_W-1:0]});
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctl_aux <= 8'h00;
      presc_sel <= PRESC_RESET;
    end else begin
      if (wr_ctl) begin
        ctl_aux[7:1] <= hwdata[7:1];
        presc_sel <= hwdata[CTL_PRESC_LSB +: PRESC_W];
      end
      // Start bit stays set until a conversion ends with free running off, or enable is written 0
      if (wr_ctl && hwdata[CTL_START] && hwdata[CTL_ENABLE]) begin
        ctl_aux[CTL_START] <= 1'b1;
      end else if ((finish && !free_run) ||
                   (wr_ctl && !hwdata[CTL_ENABLE])) begin
        ctl_aux[CTL_START] <= 1'b0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sleep_mode <= SLEEP_IDLE;
    end else if (wr_slp) begin
      sleep_mode <= hwdata[SLP_MODE_LSB +: SLP_MODE_W];
    end
  end

  // Completion flag: set wins over a write-one clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      conversion_complete_flag <= 1'b0;
    end else if (finish) begin
      conversion_complete_flag <= 1'b1;
    end else if (wr_sts && hwdata[STS_FLAG]) begin
      conversion_complete_flag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Conversion sequencer
  // ----------------------------------------------------------------
  // Sleep start armed only for idle/noise modes; other modes leave
  // the converter running untouched
  assign sleep_armed = sleep_cmd && converter_enable && !busy &&
                       (sleep_mode == SLEEP_IDLE ||
                        sleep_mode == SLEEP_NOISE);
  assign sleep_start = sleep_armed && halted_rise;

  assign begin_conv = tick && !busy && converter_enable &&
                      (start_bit || trig_pending);
  assign length = first_pending ? CNT_W'(FIRST_CYCLES) :
                                  CNT_W'(NORMAL_CYCLES);
  assign finish = tick && (state == CONV_LAST);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= CONV_IDLE;
      cycle_cnt <= '0;
    end else if (!converter_enable) begin
      state <= CONV_IDLE;
      cycle_cnt <= '0;
    end else begin
      case (state)
        CONV_IDLE: begin
          if (begin_conv || sleep_start) begin
            state <= CONV_RUN;
            cycle_cnt <= length - CNT_W'(2);
          end
        end
        CONV_RUN: begin
          if (tick) begin
            if (cycle_cnt == '0) begin
              state <= CONV_LAST;
            end else begin
              cycle_cnt <= cycle_cnt - CNT_W'(1);
            end
          end
        end
        CONV_LAST: begin
          if (tick) begin
            // Free running with auto trigger on restarts at once on the buffered selection copied in the last cycle
            if (free_run && auto_trigger_enable) begin
              state <= CONV_RUN;
              cycle_cnt <= CNT_W'(NORMAL_CYCLES - 2);
            end else begin
              state <= CONV_IDLE;
            end
          end
        end
        default: state <= CONV_IDLE;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      first_pending <= 1'b1;
    end else if (!converter_enable) begin
      first_pending <= 1'b1;
    end else if (finish) begin
      first_pending <= 1'b0;
    end
  end

  // Applied selection tracks buffer except while RUN
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      applied_sel <= selection_t'(7'h00);
    end else if (state != CONV_RUN) begin
      // Idle/last cycle copy, and capture on the start edge
      applied_sel <= sel_buffer;
    end
  end

  // ----------------------------------------------------------------
  // Core strobes, interrupt and wake
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sample_start <= 1'b0;
      conv_done <= 1'b0;
    end else begin
      sample_start <= converter_enable &&
                      ((state == CONV_IDLE && (begin_conv || sleep_start)) ||
                       (finish && free_run && auto_trigger_enable));
      conv_done <= finish;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sleep_conv <= 1'b0;
    end else if (sleep_start && converter_enable) begin
      sleep_conv <= 1'b1;
    end else if (finish || !converter_enable) begin
      sleep_conv <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      conv_irq <= 1'b0;
      cpu_wake <= 1'b0;
    end else begin
      conv_irq <= conversion_complete_flag && irq_enable;
      // Wake pulse only if still halted; CPU then stays awake
      cpu_wake <= finish && sleep_conv && halted_sync &&
                  irq_enable;
    end
  end

endmodule // conv_select_ctrl

// >>> verif/conv_core_model.sv
`timescale 1ns/1ps
module conv_core_model
  import conv_sel_pkg::*;
(
  // Clock
  input wire logic hclk,
  // Core side
  input wire conv_sel_pkg::selection_t applied_sel,
  input wire logic sample_start,
  output conv_sel_pkg::selection_t sampled
);
  // ------
  // Selection held at sampling
  // ------
  always @(posedge hclk) begin
    // Only the selection is kept; no result to settle or discard
    if (sample_start) begin
      sampled <= applied_sel;
    end
  end
endmodule // conv_core_model

// >>> verif/conv_select_checker.sv
`timescale 1ns/1ps
module conv_select_checker
  import conv_sel_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  // Core and sleep
  input wire conv_sel_pkg::selection_t applied_sel,
  input wire logic sample_start,
  input wire logic conv_done,
  input wire logic cpu_wake
);
  // ------
  // Shadow of buffer and busy state
  // ------
  logic running;
  logic pend;
  logic [1:0] quiet;
  selection_t shadow;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) running <= 1'b0;
    else if (sample_start) running <= 1'b1;
    else if (conv_done) running <= 1'b0;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend <= 1'b0;
      shadow <= 7'h00;
      quiet <= 2'h0;
    end else begin
      pend <= hsel && htrans[1] && hready && hwrite &&
              haddr[7:0] == ADDR_SELECTION;
      if (pend) begin
        shadow <= {hwdata[7:6], hwdata[4:0]};
        quiet <= 2'h0;
      end else if (quiet != 2'h3) begin
        quiet <= quiet + 2'h1;
      end
    end
  end

  // ------
  // Properties
  // ------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_sel_held;
    $stable(applied_sel) [*8];
  endsequence
  sequence s_no_done;
    !conv_done [*8];
  endsequence

  chk_sel_tracks: assert property (
    !running && quiet == 2'h3 |-> applied_sel == shadow)
    else $error("applied selection not following buffer");
  chk_sel_frozen: assert property (
    sample_start |=> s_sel_held)
    else $error("applied selection moved in conversion");
  chk_min_length: assert property (
    sample_start |=> s_no_done)
    else $error("conversion ended too early");
  chk_done_owned: assert property (
    conv_done |-> running)
    else $error("completion without a conversion");
  chk_start_pulse: assert property (
    sample_start |=> !sample_start)
    else $error("conversion restarted back to back");
  chk_wake_done: assert property (
    cpu_wake |-> conv_done || $past(conv_done))
    else $error("wake without completion");
  chk_wake_pulse: assert property (
    cpu_wake |=> !cpu_wake)
    else $error("wake longer than one cycle");
  chk_bus_okay: assert property (
    hreadyout && !hresp)
    else $error("bus not ready or not okay");
endmodule // conv_select_checker

bind conv_select_ctrl conv_select_checker conv_select_checker_i (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .applied_sel(applied_sel),
  .sample_start(sample_start), .conv_done(conv_done),
  .cpu_wake(cpu_wake)
);

// >>> verif/adc_selection_buffer_and_sleep_sequencer_bench.sv
`timescale 1ns/1ps
module adc_selection_buffer_and_sleep_sequencer_bench;
  import conv_sel_pkg::*;
  localparam logic [31:0] ST = 32'h1 << CTL_START;
  localparam logic [31:0] AU = 32'h1 << CTL_AUTO;
  localparam logic [31:0] EN = 32'h1 << CTL_ENABLE;
  localparam logic [31:0] FR = 32'h1 << CTL_FREE;
  localparam logic [31:0] IE = 32'h1 << CTL_IRQ_EN;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd, r, b;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic trigger_in, cpu_halted, sleep_cmd;
  logic sample_start, conv_done, conv_irq, cpu_wake;
  selection_t applied_sel, sampled;
  int errors = 0, samples_checked = 0, cycles = 0;
  int starts = 0, wakes = 0, m, p, s0, s1, t0;

  assign hready = hreadyout;
  conv_select_ctrl conv_select_ctrl_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .trigger_in(trigger_in), .applied_sel(applied_sel),
    .sample_start(sample_start), .conv_done(conv_done),
    .cpu_halted(cpu_halted), .sleep_cmd(sleep_cmd),
    .conv_irq(conv_irq), .cpu_wake(cpu_wake)
  );
  conv_core_model conv_core_model_i (
    .hclk(hclk), .applied_sel(applied_sel),
    .sample_start(sample_start), .sampled(sampled)
  );

  // ------
  // Clock, counters and timeout
  // ------
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (sample_start) starts <= starts + 1;
    if (cpu_wake) wakes <= wakes + 1;
    if (cycles == 20000) begin
      errors++;
      stop_test();
    end
  end

  // ------
  // Bus, waits and checks
  // ------
  function automatic logic [31:0] to_sel(input logic [31:0] w);
    return {25'h0, w[7:6], w[4:0]};
  endfunction

  function automatic int exp_len(input bit first, input int ps);
    return (first ? FIRST_CYCLES : NORMAL_CYCLES) << (ps + 1);
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h000000, a};
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask

  task automatic wait_ev(input bit on_done);
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while ((on_done ? conv_done : sample_start) !== 1'b1 && n < 600);
    if (n >= 600) begin
      errors++;
      $display("unexpected at %0t: wait ran out", $time);
    end
  endtask

  task automatic stop_test();
    $display("errors %0d checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ------
  // Scenarios
  // ------
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    trigger_in = 1'b0;
    cpu_halted = 1'b0;
    sleep_cmd = 1'b0;
    hresetn = 1'b0;
    void'($urandom(54));
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b0, ADDR_SELECTION, 32'h0);
    check(rd, {24'h0, SEL_RESET});
    bus(1'b0, 8'h10, 32'h0);
    check(rd, 32'h0);
    for (int i = 0; i < 4; i++) begin
      r = $urandom;
      b = $urandom;
      p = $urandom % 3;
      bus(1'b1, ADDR_SELECTION, r);
      bus(1'b0, ADDR_SELECTION, 32'h0);
      check(to_sel(rd), to_sel(r));
      bus(1'b1, ADDR_CONTROL, EN | ST | (p << CTL_PRESC_LSB));
      wait_ev(1'b0);
      t0 = cycles;
      bus(1'b1, ADDR_SELECTION, b);
      check(sampled, to_sel(r));
      check(applied_sel, to_sel(r));
      wait_ev(1'b1);
      check(cycles - t0, exp_len(i == 0, p));
      @(posedge hclk);
      check(applied_sel, to_sel(b));
      bus(1'b0, ADDR_STATUS, 32'h0);
      check(rd[STS_BUSY:STS_FLAG], 2'h1);
      bus(1'b1, ADDR_STATUS, 32'h1);
    end
    r = $urandom;
    b = $urandom;
    bus(1'b1, ADDR_SELECTION, r);
    bus(1'b1, ADDR_CONTROL, EN | AU | FR | ST);
    wait_ev(1'b1);
    bus(1'b1, ADDR_SELECTION, b);
    wait_ev(1'b1);
    check(sampled, to_sel(r));
    wait_ev(1'b1);
    check(sampled, to_sel(b));
    bus(1'b1, ADDR_CONTROL, EN);
    wait_ev(1'b1);
    bus(1'b1, ADDR_STATUS, 32'h1);
    bus(1'b1, ADDR_CONTROL, EN | AU | (32'h2 << CTL_PRESC_LSB));
    for (int i = 0; i < 2; i++) begin
      repeat ($urandom % 7) @(posedge hclk);
      trigger_in <= 1'b1;
      t0 = cycles;
      // Second pass: pulse shorter than a converter clock
      if (i == 1) begin
        repeat (2) @(posedge hclk);
        trigger_in <= 1'b0;
      end
      wait_ev(1'b0);
      if (i == 0) m = cycles - t0;
      check(cycles - t0, m);
      trigger_in <= 1'b0;
      repeat (3) @(posedge hclk);
      trigger_in <= 1'b1;
      repeat (3) @(posedge hclk);
      trigger_in <= 1'b0;
      s0 = starts;
      wait_ev(1'b1);
      repeat (12) @(posedge hclk);
      check(starts, s0);
      bus(1'b1, ADDR_STATUS, 32'h1);
    end
    bus(1'b1, ADDR_CONTROL, EN | IE);
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, ADDR_STATUS, 32'h1);
      bus(1'b1, ADDR_SLEEP, {29'h0, i == 0 ? SLEEP_IDLE : SLEEP_NOISE});
      s0 = wakes;
      sleep_cmd <= 1'b1;
      cpu_halted <= 1'b1;
      wait_ev(1'b0);
      if (i == 2) cpu_halted <= 1'b0;
      wait_ev(1'b1);
      s1 = starts;
      repeat (40) @(posedge hclk);
      check(wakes, s0 + (i < 2));
      check(conv_irq, 1'b1);
      check(starts, s1);
      cpu_halted <= 1'b0;
      sleep_cmd <= 1'b0;
      repeat (3) @(posedge hclk);
    end
    bus(1'b1, ADDR_SLEEP, 32'h2);
    s0 = starts;
    sleep_cmd <= 1'b1;
    cpu_halted <= 1'b1;
    repeat (40) @(posedge hclk);
    check(starts, s0);
    bus(1'b0, ADDR_CONTROL, 32'h0);
    check(rd[CTL_ENABLE], 1'b1);
    bus(1'b1, ADDR_CONTROL, 32'h0);
    cpu_halted <= 1'b0;
    sleep_cmd <= 1'b0;
    bus(1'b1, ADDR_CONTROL, EN | ST);
    wait_ev(1'b0);
    t0 = cycles;
    wait_ev(1'b1);
    check(cycles - t0, exp_len(1'b1, 0));
    stop_test();
  end
endmodule // adc_selection_buffer_and_sleep_sequencer_bench
